//--- pkg/otg_pkg.sv
// Purpose: Shared constants for the OTG ID and VBUS status logic.
// Assumes: Registers sit on a 32-bit Avalon-MM slave, one aligned word each.
// Notes: Comparator slots share one index space with the status bit positions.

package otg_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_OTG_CTL = 8'h00;
   localparam logic [7:0] OFS_IND_CTL = 8'h04;
   localparam logic [7:0] OFS_RISE_EN = 8'h08;
   localparam logic [7:0] OFS_FALL_EN = 8'h0C;
   localparam logic [7:0] OFS_ISTAT = 8'h10;
   localparam logic [7:0] OFS_CK_EN = 8'h14;
   localparam logic [7:0] OFS_CK_STAT = 8'h18;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned NCMP = 5;
   localparam int unsigned CMP_FLOAT = 0;
   localparam int unsigned CMP_VBUS = 1;
   localparam int unsigned CMP_SESSV = 2;
   localparam int unsigned CMP_SESSE = 3;
   localparam int unsigned CMP_ID_GROUNDED = 4;
   localparam int unsigned BIT_PULLUP = 0;
   localparam int unsigned BIT_DISCHG = 3;
   localparam int unsigned BIT_CHG = 4;
   localparam int unsigned BIT_SEL = 0;
   localparam int unsigned BIT_PASS = 1;
   localparam int unsigned BIT_INV = 2;
   localparam int unsigned CK_RISE = 0;
   localparam int unsigned CK_FALL = 1;

   // ----------------------------------------------------------------
   // Reset values and fixed levels
   // ----------------------------------------------------------------
   localparam logic [4:0] OTG_CTL_RST = 5'h00;
   localparam logic [2:0] IND_CTL_RST = 3'h0;
   localparam logic [4:0] EDGE_EN_RST = 5'h00;
   localparam logic [1:0] CK_EN_RST = 2'h0;
   localparam logic EXT_VBUS_IND = 1'b1;

endpackage

//--- pkg/cmp_sync_if.sv
// Purpose: Carries synchronised comparator levels and edge pulses.
// Assumes: One clock domain, the sys_clk of both ends.
// Notes: Rise and fall are one-cycle pulses aligned with the level change.

`timescale 1ns/10ps

interface cmp_sync_if;
   logic [otg_pkg::NCMP-1:0] lvl;
   logic [otg_pkg::NCMP-1:0] rise;
   logic [otg_pkg::NCMP-1:0] fall;
   modport src (output lvl, output rise, output fall);
   modport snk (input lvl, input rise, input fall);
endinterface

//--- design/cmp_sync.sv
// Purpose: Brings the analog comparator outputs into the sys_clk domain.
// Assumes: Raw inputs are asynchronous levels from the analog front end.
// Notes: Three flops; a level counts once the second and third stages agree.

`timescale 1ns/10ps

module cmp_sync (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [otg_pkg::NCMP-1:0] raw,
   cmp_sync_if.src o
);

   typedef struct packed {
      logic [otg_pkg::NCMP-1:0] s1;
      logic [otg_pkg::NCMP-1:0] s2;
      logic [otg_pkg::NCMP-1:0] s3;
      logic [otg_pkg::NCMP-1:0] lvl;
      logic [otg_pkg::NCMP-1:0] rise;
      logic [otg_pkg::NCMP-1:0] fall;
   } sync_st_t;

   sync_st_t st_q;
   sync_st_t st_d;

   // ----------------------------------------------------------------
   // Synchroniser and edge detection
   // ----------------------------------------------------------------
   // The first stage feeds only the second, so a metastable sample never
   // reaches the agreement check or the edge detector.
   always_comb begin
      st_d = st_q;
      st_d.s1 = raw;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < otg_pkg::NCMP; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.lvl[i] = st_q.s3[i];
         end
      end
      st_d.rise = st_d.lvl & ~st_q.lvl;
      st_d.fall = ~st_d.lvl & st_q.lvl;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o.lvl = st_q.lvl;
   assign o.rise = st_q.rise;
   assign o.fall = st_q.fall;

   AST_SYNC_AGREE: assert property (@(posedge sys_clk) disable iff (rst)
      (st_q.lvl != $past(st_q.lvl)) |-> $past(st_q.s2 == st_q.s3) && ($past(st_q.s3) == st_q.lvl))
      else $error("Level changed without stage agreement.");

endmodule

//--- design/otg_id_vbus_status.sv
// Purpose: ID and VBUS comparator status, edge enables and VBUS pulsing controls.
// Assumes: sys_clk at 200 MHz, asynchronous active-high rst, Avalon-MM slave.
// Notes: Receive commands leave as a registered one-cycle pulse with fields.
//
// How it works
// - Pull-up on and both float enables set: every float change sends alternate command.
// - id_pullup_on set connects the 100k ID pull-up; cleared removes it.
// - Floating gives 1/1, 102K gives 1/0, grounded gives 0/0 on grounded/float.
// - Live id_grounded reads at interrupt status bit 4.
// - Live id_float_detect reads at carkit status bit 0.
// - Host may enable grounded edges so any id_grounded change raises an event.
// - Session-end, session-valid and VBUS-valid levels readable in interrupt status.
// - session_end_flag rises when VBUS drops below 0.5 volts.
// - Both session-end enables clear: comparator off and its status reads 0.
// - Clearing session-valid enables stops only events; its status stays live.
// - One session_valid_flag serves both A-device and B-device roles.
// - Both VBUS-valid enables clear: comparator off, status bit 1 reads 0.
// - vbus_valid_flag shows VBUS above 4.4V for the A-device supply check.
// - External VBUS-valid indicator input is tied to constant one.
// - After reset ext_indicator_select is 0, reporting the internal comparator.
// - OTG control bit 3 vbus_discharge_ctl switches the VBUS pull-down.
// - OTG control bit 4 vbus_charge_ctl switches the VBUS pull-up.

`timescale 1ns/10ps

module otg_id_vbus_status (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic cmp_id_float_raw,
   input wire logic cmp_vbus_valid_raw,
   input wire logic cmp_session_valid_raw,
   input wire logic cmp_session_end_raw,
   input wire logic cmp_id_grounded_raw,
   output logic id_pullup_on,
   output logic vbus_discharge_ctl,
   output logic vbus_charge_ctl,
   output logic session_end_cmp_en,
   output logic vbus_valid_cmp_en,
   output logic rxcmd_valid,
   output logic rxcmd_alternate_irq_flag,
   output logic rxcmd_vbus_valid,
   output logic rxcmd_session_valid,
   output logic rxcmd_session_end,
   output logic rxcmd_id_grounded
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] otg_ctl;
      logic [2:0] ind_ctl;
      logic [4:0] rise_en;
      logic [4:0] fall_en;
      logic [1:0] ck_en;
      logic ack;
      logic [31:0] rdata;
      logic rx_valid;
      logic rx_alt;
      logic rx_vbus;
      logic rx_sessv;
      logic rx_sesse;
      logic rx_idg;
   } ctl_st_t;

   ctl_st_t st_q;
   ctl_st_t st_d;

   cmp_sync_if cmp ();

   logic [otg_pkg::NCMP-1:0] raw_cmp;
   logic sesse_on;
   logic vbus_on;
   logic [4:0] istat;
   logic vbus_vld;
   logic sesse_flag;
   logic ulpi_evt;
   logic float_evt;
   logic [4:0] gate_rise;
   logic [4:0] gate_fall;

   assign raw_cmp = {cmp_id_grounded_raw, cmp_session_end_raw, cmp_session_valid_raw,
                     cmp_vbus_valid_raw, cmp_id_float_raw};

   cmp_sync u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .raw(raw_cmp),
      .o(cmp)
   );

   // ----------------------------------------------------------------
   // Indicator decode
   // ----------------------------------------------------------------
   // The external indicator is tied high, so passthrough only ever yields
   // a fixed level; inversion forces 0 in both external paths.
   function automatic logic vbus_src(input logic [2:0] ind, input logic cmp_lvl);
      logic res;
      res = cmp_lvl;
      if (!ind[otg_pkg::BIT_SEL]) begin
         res = cmp_lvl;
      end else if (ind[otg_pkg::BIT_PASS]) begin
         res = otg_pkg::EXT_VBUS_IND & ~ind[otg_pkg::BIT_INV];
      end else begin
         res = cmp_lvl & ~ind[otg_pkg::BIT_INV];
      end
      return res;
   endfunction

   // ----------------------------------------------------------------
   // Status and events
   // ----------------------------------------------------------------
   always_comb begin
      sesse_on = st_q.rise_en[otg_pkg::CMP_SESSE] | st_q.fall_en[otg_pkg::CMP_SESSE];
      vbus_on = st_q.rise_en[otg_pkg::CMP_VBUS] | st_q.fall_en[otg_pkg::CMP_VBUS];
      // VBUS-valid means VBUS is above 4.4V.
      vbus_vld = cmp.lvl[otg_pkg::CMP_VBUS] & vbus_on;
      sesse_flag = cmp.lvl[otg_pkg::CMP_SESSE] & sesse_on;
      istat = 5'h00;
      istat[otg_pkg::CMP_ID_GROUNDED] = cmp.lvl[otg_pkg::CMP_ID_GROUNDED];
      istat[otg_pkg::CMP_SESSE] = sesse_flag;
      istat[otg_pkg::CMP_SESSV] = cmp.lvl[otg_pkg::CMP_SESSV];
      istat[otg_pkg::CMP_VBUS] = vbus_vld;
      // Slot 0 is the float comparator, which only reads in carkit status.
      gate_rise = cmp.rise & st_q.rise_en;
      gate_fall = cmp.fall & st_q.fall_en;
      gate_rise[otg_pkg::CMP_FLOAT] = 1'b0;
      gate_fall[otg_pkg::CMP_FLOAT] = 1'b0;
      ulpi_evt = |{gate_rise, gate_fall};
      float_evt = (cmp.rise[otg_pkg::CMP_FLOAT] & st_q.ck_en[otg_pkg::CK_RISE]) |
                  (cmp.fall[otg_pkg::CMP_FLOAT] & st_q.ck_en[otg_pkg::CK_FALL]);
   end

   // ----------------------------------------------------------------
   // Register bus and command generation
   // ----------------------------------------------------------------
   // One wait cycle per access: read data is prepared while waitrequest is
   // high, so it stands registered on the cycle the master samples it.
   always_comb begin
      st_d = st_q;
      st_d.ack = (avs_read | avs_write) & ~st_q.ack;
      if ((avs_read | avs_write) && !st_q.ack) begin
         st_d.rdata = 32'h0000_0000;
         if (avs_address == otg_pkg::OFS_OTG_CTL) begin
            st_d.rdata[4:0] = st_q.otg_ctl;
         end else if (avs_address == otg_pkg::OFS_IND_CTL) begin
            st_d.rdata[2:0] = st_q.ind_ctl;
         end else if (avs_address == otg_pkg::OFS_RISE_EN) begin
            st_d.rdata[4:0] = st_q.rise_en;
         end else if (avs_address == otg_pkg::OFS_FALL_EN) begin
            st_d.rdata[4:0] = st_q.fall_en;
         end else if (avs_address == otg_pkg::OFS_ISTAT) begin
            st_d.rdata[4:0] = istat;
         end else if (avs_address == otg_pkg::OFS_CK_EN) begin
            st_d.rdata[1:0] = st_q.ck_en;
         end else if (avs_address == otg_pkg::OFS_CK_STAT) begin
            st_d.rdata[0] = cmp.lvl[otg_pkg::CMP_FLOAT];
         end
      end
      if (avs_write && st_q.ack && avs_byteenable[0]) begin
         if (avs_address == otg_pkg::OFS_OTG_CTL) begin
            st_d.otg_ctl = avs_writedata[4:0];
         end else if (avs_address == otg_pkg::OFS_IND_CTL) begin
            st_d.ind_ctl = avs_writedata[2:0];
         end else if (avs_address == otg_pkg::OFS_RISE_EN) begin
            st_d.rise_en = avs_writedata[4:0];
         end else if (avs_address == otg_pkg::OFS_FALL_EN) begin
            st_d.fall_en = avs_writedata[4:0];
         end else if (avs_address == otg_pkg::OFS_CK_EN) begin
            st_d.ck_en = avs_writedata[1:0];
         end
      end
      st_d.rx_valid = ulpi_evt | float_evt;
      if (ulpi_evt || float_evt) begin
         st_d.rx_alt = float_evt;
         st_d.rx_vbus = vbus_src(st_q.ind_ctl, vbus_vld);
         st_d.rx_sessv = cmp.lvl[otg_pkg::CMP_SESSV];
         st_d.rx_sesse = sesse_flag;
         st_d.rx_idg = cmp.lvl[otg_pkg::CMP_ID_GROUNDED];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
         st_q.otg_ctl <= otg_pkg::OTG_CTL_RST;
         st_q.ind_ctl <= otg_pkg::IND_CTL_RST;
         st_q.rise_en <= otg_pkg::EDGE_EN_RST;
         st_q.fall_en <= otg_pkg::EDGE_EN_RST;
         st_q.ck_en <= otg_pkg::CK_EN_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign avs_waitrequest = (avs_read | avs_write) & ~st_q.ack;
   assign avs_readdata = st_q.rdata;
   assign id_pullup_on = st_q.otg_ctl[otg_pkg::BIT_PULLUP];
   assign vbus_discharge_ctl = st_q.otg_ctl[otg_pkg::BIT_DISCHG];
   assign vbus_charge_ctl = st_q.otg_ctl[otg_pkg::BIT_CHG];
   // Disabling these two comparators saves their bias current.
   assign session_end_cmp_en = sesse_on;
   assign vbus_valid_cmp_en = vbus_on;
   assign rxcmd_valid = st_q.rx_valid;
   assign rxcmd_alternate_irq_flag = st_q.rx_alt;
   assign rxcmd_vbus_valid = st_q.rx_vbus;
   assign rxcmd_session_valid = st_q.rx_sessv;
   assign rxcmd_session_end = st_q.rx_sesse;
   assign rxcmd_id_grounded = st_q.rx_idg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking dclk @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   AST_FLOAT_CMD: assert property (
      (id_pullup_on && (&st_q.ck_en) && (cmp.rise[0] || cmp.fall[0]))
      |=> rxcmd_valid && rxcmd_alternate_irq_flag)
      else $error("Float change did not send an alternate command.");

   AST_PULLUP_WRITE: assert property (
      (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 8'h00)
      |=> id_pullup_on == $past(avs_writedata[0]))
      else $error("Pull-up control did not follow the write.");

   AST_SESSE_OFF: assert property (
      (!session_end_cmp_en) |-> !istat[3] && !session_end_cmp_en ##1 (!session_end_cmp_en || istat[3] == cmp.lvl[3]))
      else $error("Session end status read high while disabled.");

   AST_VBUS_OFF: assert property (
      (!vbus_valid_cmp_en && avs_read && avs_address == 8'h10 && avs_waitrequest)
      |=> !avs_readdata[1])
      else $error("VBUS valid status read high while disabled.");

   AST_VBUS_INTERNAL: assert property (
      (rxcmd_valid && !$past(st_q.ind_ctl[0])) |-> rxcmd_vbus_valid == $past(vbus_vld))
      else $error("Command VBUS field did not follow the comparator.");

   AST_DISCHARGE: assert property (
      $changed(vbus_discharge_ctl) |-> $past(avs_write && !avs_waitrequest && avs_address == 8'h00))
      else $error("Discharge control changed without a write.");

   AST_CHARGE: assert property (
      $changed(vbus_charge_ctl) |-> $past(avs_write && avs_address == 8'h00) && vbus_charge_ctl == $past(avs_writedata[4]))
      else $error("Charge control changed without a matching write.");

   AST_EDGE_ENABLE: assert property (
      rxcmd_valid |-> $past(|(cmp.rise & {st_q.rise_en[4:1], st_q.ck_en[0]})) || $past(|(cmp.fall & {st_q.fall_en[4:1], st_q.ck_en[1]})))
      else $error("Command sent without an enabled edge.");

   AST_ID_GROUNDED_STATUS: assert property (
      (avs_read && avs_waitrequest && avs_address == otg_pkg::OFS_ISTAT)
      |=> avs_readdata[otg_pkg::CMP_ID_GROUNDED] == $past(cmp.lvl[otg_pkg::CMP_ID_GROUNDED]))
      else $error("Grounded status did not read the live level.");

   AST_SESSV_LIVE: assert property (
      (avs_read && avs_waitrequest && avs_address == otg_pkg::OFS_ISTAT)
      |=> avs_readdata[otg_pkg::CMP_SESSV] == $past(cmp.lvl[otg_pkg::CMP_SESSV]))
      else $error("Session valid status did not read the live level.");

   AST_FLOAT_STATUS: assert property (
      (avs_read && avs_waitrequest && avs_address == otg_pkg::OFS_CK_STAT)
      |=> avs_readdata[0] == $past(cmp.lvl[otg_pkg::CMP_FLOAT]))
      else $error("Float status did not read the live level.");

endmodule

//--- test/link_model.sv
// Purpose: Link-side model that collects receive commands from the block.
// Assumes: A command is a one-cycle pulse of rxcmd_valid on sys_clk.
// Notes: Only the latest fields are kept, so a burst of commands shows as a count.

`timescale 1ns/10ps

module link_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic rxcmd_valid,
   input wire logic [4:0] fields,
   output int cmd_count,
   output logic [4:0] last_fields
);
   // The pulse stands one cycle, so it is sampled at every edge.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmd_count <= 0;
         last_fields <= 5'h00;
      end else if (rxcmd_valid === 1'b1) begin
         cmd_count <= cmd_count + 1;
         last_fields <= fields;
      end
   end
endmodule

//--- test/otg_id_vbus_status_bench.sv
// Purpose: Self-checking bench for the OTG ID and VBUS status logic.
// Assumes: Avalon-MM accesses through shared tasks; comparators driven as levels.
// Notes: Absent commands are judged after a fixed settle span past the synchroniser.

`timescale 1ns/10ps

module otg_id_vbus_status_bench;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [4:0] raw = 5'h00;
   logic id_pullup_on, vbus_discharge_ctl, vbus_charge_ctl, session_end_cmp_en, vbus_valid_cmp_en;
   logic rxcmd_valid, rxcmd_alternate_irq_flag, rxcmd_vbus_valid, rxcmd_session_valid;
   logic rxcmd_session_end, rxcmd_id_grounded;
   logic [4:0] last_fields;
   int cmd_count;
   int num_errors = 0;
   int check_count = 0;

   always #2.5 sys_clk = ~sys_clk;

   otg_id_vbus_status uut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cmp_id_float_raw(raw[otg_pkg::CMP_FLOAT]), .cmp_vbus_valid_raw(raw[otg_pkg::CMP_VBUS]),
      .cmp_session_valid_raw(raw[otg_pkg::CMP_SESSV]), .cmp_session_end_raw(raw[otg_pkg::CMP_SESSE]),
      .cmp_id_grounded_raw(raw[otg_pkg::CMP_ID_GROUNDED]), .id_pullup_on(id_pullup_on),
      .vbus_discharge_ctl(vbus_discharge_ctl), .vbus_charge_ctl(vbus_charge_ctl),
      .session_end_cmp_en(session_end_cmp_en), .vbus_valid_cmp_en(vbus_valid_cmp_en),
      .rxcmd_valid(rxcmd_valid), .rxcmd_alternate_irq_flag(rxcmd_alternate_irq_flag),
      .rxcmd_vbus_valid(rxcmd_vbus_valid), .rxcmd_session_valid(rxcmd_session_valid),
      .rxcmd_session_end(rxcmd_session_end), .rxcmd_id_grounded(rxcmd_id_grounded));

   link_model link (.sys_clk(sys_clk), .rst(rst), .rxcmd_valid(rxcmd_valid),
      .fields({rxcmd_alternate_irq_flag, rxcmd_vbus_valid, rxcmd_session_valid, rxcmd_session_end,
      rxcmd_id_grounded}), .cmd_count(cmd_count), .last_fields(last_fields));

   task automatic fail(input string msg);
      $display("CHECK FAILED at %0t: %s", $time, msg);
      num_errors++;
   endtask

   task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) fail(msg);
   endtask

   task automatic check1(input logic got, input logic exp, input string msg);
      check_count++;
      if (got !== exp) fail(msg);
   endtask

   // The request is held until waitrequest is seen low at an edge; data is taken there.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      // The register changes at the accepting edge, so its outputs are looked at one edge later.
      @(posedge sys_clk);
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      check32(q, exp, msg);
   endtask

   // Changes one comparator level and checks how many commands follow it.
   task automatic edge_cmd(input int idx, input logic v, input int exp);
      int c0;
      c0 = cmd_count;
      @(posedge sys_clk);
      raw[idx] <= v;
      repeat (8) @(posedge sys_clk);
      check32(32'(cmd_count - c0), 32'(exp), "command count after level change");
   endtask

   task automatic summarize();
      $display("errors %0d, checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #100000;
      fail("watchdog expired");
      summarize();
   end

   initial begin
      logic [7:0] ofs [5];
      logic [1:0] cab [3];
      logic e;
      ofs = '{otg_pkg::OFS_OTG_CTL, otg_pkg::OFS_IND_CTL, otg_pkg::OFS_RISE_EN, otg_pkg::OFS_FALL_EN,
         otg_pkg::OFS_CK_EN};
      cab = '{2'b11, 2'b10, 2'b00};
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (ofs[i]) chk_rd(ofs[i], 32'h0000_0000, "reset value");
      chk_rd(8'h1C, 32'h0000_0000, "unmapped read");
      check32(32'({id_pullup_on, vbus_discharge_ctl, vbus_charge_ctl}), 32'h0000_0000, "controls at reset");
      wr(otg_pkg::OFS_OTG_CTL, 32'h0000_0019);
      check32(32'({id_pullup_on, vbus_discharge_ctl, vbus_charge_ctl}), 32'h0000_0007, "controls on");
      avs_byteenable <= 4'h0;
      wr(otg_pkg::OFS_OTG_CTL, 32'h0000_0000);
      avs_byteenable <= 4'hF;
      chk_rd(otg_pkg::OFS_OTG_CTL, 32'h0000_0019, "write without byte lane");
      wr(otg_pkg::OFS_OTG_CTL, 32'h0000_0011);
      check32(32'({id_pullup_on, vbus_discharge_ctl, vbus_charge_ctl}), 32'h0000_0005, "discharge off");
      wr(otg_pkg::OFS_RISE_EN, 32'h0000_001E);
      wr(otg_pkg::OFS_FALL_EN, 32'h0000_001E);
      wr(otg_pkg::OFS_ISTAT, 32'h0000_001F);
      check1(session_end_cmp_en & vbus_valid_cmp_en, 1'b1, "comparators enabled");
      // Status reads are only trusted once the synchroniser has settled.
      foreach (cab[i]) begin
         @(posedge sys_clk);
         raw <= {cab[i][1], 3'b111, cab[i][0]};
         repeat (8) @(posedge sys_clk);
         chk_rd(otg_pkg::OFS_ISTAT, {27'h0, cab[i][1], 4'hE}, "interrupt status");
         chk_rd(otg_pkg::OFS_CK_STAT, {31'h0, cab[i][0]}, "float status");
      end
      wr(otg_pkg::OFS_CK_EN, 32'h0000_0003);
      edge_cmd(otg_pkg::CMP_FLOAT, 1'b1, 1);
      check1(last_fields[4], 1'b1, "alternate flag on float rise");
      edge_cmd(otg_pkg::CMP_FLOAT, 1'b0, 1);
      check1(last_fields[4], 1'b1, "alternate flag on float fall");
      wr(otg_pkg::OFS_CK_EN, 32'h0000_0001);
      edge_cmd(otg_pkg::CMP_FLOAT, 1'b1, 1);
      edge_cmd(otg_pkg::CMP_FLOAT, 1'b0, 0);
      wr(otg_pkg::OFS_RISE_EN, 32'h0000_0010);
      wr(otg_pkg::OFS_FALL_EN, 32'h0000_0000);
      check32(32'({session_end_cmp_en, vbus_valid_cmp_en}), 32'h0000_0000, "comparators off");
      chk_rd(otg_pkg::OFS_ISTAT, 32'h0000_0004, "gated status, live session valid");
      edge_cmd(otg_pkg::CMP_SESSV, 1'b0, 0);
      chk_rd(otg_pkg::OFS_ISTAT, 32'h0000_0000, "session valid stays live");
      edge_cmd(otg_pkg::CMP_ID_GROUNDED, 1'b1, 1);
      check32(32'(last_fields), 32'h0000_0001, "grounded rise fields");
      edge_cmd(otg_pkg::CMP_ID_GROUNDED, 1'b0, 0);
      wr(otg_pkg::OFS_RISE_EN, 32'h0000_0008);
      wr(otg_pkg::OFS_FALL_EN, 32'h0000_0010);
      edge_cmd(otg_pkg::CMP_ID_GROUNDED, 1'b1, 0);
      edge_cmd(otg_pkg::CMP_ID_GROUNDED, 1'b0, 1);
      edge_cmd(otg_pkg::CMP_SESSE, 1'b0, 0);
      edge_cmd(otg_pkg::CMP_SESSE, 1'b1, 1);
      check1(last_fields[1], 1'b1, "session end field");
      wr(otg_pkg::OFS_RISE_EN, 32'h0000_0012);
      wr(otg_pkg::OFS_FALL_EN, 32'h0000_0012);
      for (int m = 0; m < 8; m++) begin
         for (int v = 0; v < 2; v++) begin
            wr(otg_pkg::OFS_IND_CTL, 32'(m));
            @(posedge sys_clk);
            raw[otg_pkg::CMP_VBUS] <= v[0];
            repeat (8) @(posedge sys_clk);
            edge_cmd(otg_pkg::CMP_ID_GROUNDED, ~raw[otg_pkg::CMP_ID_GROUNDED], 1);
            e = !m[0] ? v[0] : (m[1] ? ~m[2] : (~m[2] & v[0]));
            check1(last_fields[3], e, "indicator decode");
         end
      end
      // Saving current after an A plug leaves float changes silent.
      wr(otg_pkg::OFS_OTG_CTL, 32'h0000_0000);
      wr(otg_pkg::OFS_CK_EN, 32'h0000_0000);
      check1(id_pullup_on, 1'b0, "pull-up removed");
      edge_cmd(otg_pkg::CMP_FLOAT, 1'b1, 0);
      summarize();
   end
endmodule
